// >>> dma_cnt_regs.sv
// Purpose: per-channel count, base, mode and request/mask logic
// Assumes: inputs synchronous to i_clk_sys; byte-wide host access
// Notes: cycle engine reports finished transfers through a fifo
`timescale 1ns/10ps
`include "dma_cnt_map.svh"

module dma_cnt_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0] cnt, next_cnt;
    logic next_ready, next_valid, push, pop;

    // flags are registered so the ready seen upstream is a flop
    always_comb begin
        push = i_wr_valid && o_wr_ready;
        pop = o_rd_valid && i_rd_ready;
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
        next_ready = next_cnt != (AW+1)'(DEPTH);
        next_valid = next_cnt != '0;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
            o_wr_ready <= 1'b1;
            o_rd_valid <= 1'b0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt <= next_cnt;
            o_wr_ready <= next_ready;
            o_rd_valid <= next_valid;
        end
    end

    // storage only, no reset needed
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wptr] <= i_wr_data;
        end
    end

    assign o_rd_data = mem[rptr];
endmodule

module dma_cnt_regs (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    input wire logic [7:0] i_dreq,
    input wire logic [7:0] i_chain_en,
    input wire logic i_dack_valid,
    input wire logic [2:0] i_dack_ch,
    input wire logic i_xfer_valid,
    input wire logic [5:0] i_xfer_rec,
    output logic o_xfer_ready,
    input wire logic i_eop_in,
    output logic o_eop_out,
    output logic o_eop_oe,
    output logic [7:0] o_terminal_count,
    output logic [7:0] o_req_pending,
    output logic [7:0] o_stop_cmp_en,
    output logic [2:0] o_addr_step,
    output logic o_addr_shift,
    output logic [1:0] o_master_clear
);
    logic [23:0] cur_cnt [8], next_cur_cnt [8];
    logic [23:0] base_cnt [8], next_base_cnt [8];
    dma_cnt_pkg::chan_mode_t mode [8], next_mode [8];
    dma_cnt_pkg::ext_mode_t xmode [8], next_xmode [8];
    logic [7:0] cmd [2], next_cmd [2];
    logic [7:0] swreq, next_swreq, mask, next_mask;
    logic [1:0] bptr, next_bptr;
    logic [2:0] xsel [2], next_xsel [2];
    logic [7:0] next_rdata, next_tc, next_req, next_stop;
    logic next_eop_out, next_eop_oe, next_shift;
    logic [2:0] next_step;
    logic [1:0] next_mclr;
    logic fifo_valid, pop;
    logic [5:0] fifo_data;
    dma_cnt_pkg::xfer_rec_t rec;
    logic [23:0] dec;
    logic [7:0] end_evt;
    logic [2:0] ch;
    logic g;
    logic [2:0] wch;

    // cycle engine reports drain through the fifo; a host write stalls it
    dma_cnt_fifo #(
        .WIDTH(6),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_wr_valid(i_xfer_valid),
        .o_wr_ready(o_xfer_ready),
        .i_wr_data(i_xfer_rec),
        .o_rd_valid(fifo_valid),
        .i_rd_ready(pop),
        .o_rd_data(fifo_data)
    );

    // host writes win the cycle so count writes never race a decrement
    assign pop = fifo_valid && !i_io_wr;
    assign rec = dma_cnt_pkg::xfer_rec_t'(fifo_data);

    // next state of all programming and counting registers
    always_comb begin
        next_cur_cnt = cur_cnt;
        next_base_cnt = base_cnt;
        next_mode = mode;
        next_xmode = xmode;
        next_cmd = cmd;
        next_swreq = swreq;
        next_mask = mask;
        next_bptr = bptr;
        next_xsel = xsel;
        next_rdata = 8'h00;
        next_tc = 8'h00;
        next_mclr = 2'h0;
        end_evt = 8'h00;
        dec = 24'h000000;
        ch = rec.ch;
        g = 1'b0;
        wch = {g, i_io_wdata[1:0]};
        // group from the port address; only count ports use address bit 2
        if (i_io_addr == `CMD_G1 || i_io_addr == `REQ_G1 ||
            i_io_addr == `MASK1_G1 || i_io_addr == `MODE_G1 ||
            i_io_addr == `CLRBP_G1 || i_io_addr == `MCLR_G1 ||
            i_io_addr == `CLRMSK_G1 || i_io_addr == `MASKALL_G1 ||
            i_io_addr == `XMODE_LO_G1 || i_io_addr == `XMODE_HI_G1 ||
            ((i_io_addr[7:3] == `CNT_PORT_BASE >> 3 ||
              i_io_addr[7:3] == `CNT_HI_BASE >> 3) && i_io_addr[2])) begin
            g = 1'b1;
        end
        wch = {g, i_io_wdata[1:0]};
        if (i_io_wr) begin
            if (i_io_addr[7:3] == `CNT_PORT_BASE >> 3) begin
                // low then middle byte; high byte cleared either way
                if (!bptr[g]) begin
                    next_cur_cnt[i_io_addr[2:0]][7:0] = i_io_wdata;
                    next_base_cnt[i_io_addr[2:0]][7:0] = i_io_wdata;
                end else begin
                    next_cur_cnt[i_io_addr[2:0]][15:8] = i_io_wdata;
                    next_base_cnt[i_io_addr[2:0]][15:8] = i_io_wdata;
                end
                next_cur_cnt[i_io_addr[2:0]][23:16] = 8'h00;
                next_base_cnt[i_io_addr[2:0]][23:16] = 8'h00;
                next_bptr[g] = !bptr[g];
            end else if (i_io_addr[7:3] == `CNT_HI_BASE >> 3) begin
                next_cur_cnt[i_io_addr[2:0]][23:16] = i_io_wdata;
                next_base_cnt[i_io_addr[2:0]][23:16] = i_io_wdata;
            end else if (i_io_addr == `CMD_G0 || i_io_addr == `CMD_G1) begin
                next_cmd[g] = i_io_wdata;
            end else if (i_io_addr == `MODE_G0 || i_io_addr == `MODE_G1) begin
                next_mode[wch] = i_io_wdata[7:2];
            end else if (i_io_addr == `XMODE_LO_G0 ||
                         i_io_addr == `XMODE_LO_G1) begin
                next_xmode[wch][7:0] = i_io_wdata;
                next_xsel[g] = wch;
            end else if (i_io_addr == `XMODE_HI_G0 ||
                         i_io_addr == `XMODE_HI_G1) begin
                next_xmode[xsel[g]].upper = i_io_wdata;
            end else if (i_io_addr == `REQ_G0 || i_io_addr == `REQ_G1) begin
                next_swreq[wch] = i_io_wdata[`SETBIT_POS];
            end else if (i_io_addr == `MASK1_G0 ||
                         i_io_addr == `MASK1_G1) begin
                next_mask[wch] = i_io_wdata[`SETBIT_POS];
            end else if (i_io_addr == `MASKALL_G0 ||
                         i_io_addr == `MASKALL_G1) begin
                next_mask[{g, 2'h0} +: 4] = i_io_wdata[3:0];
            end else if (i_io_addr == `CLRMSK_G0 ||
                         i_io_addr == `CLRMSK_G1) begin
                next_mask[{g, 2'h0} +: 4] = 4'h0;
            end else if (i_io_addr == `CLRBP_G0 ||
                         i_io_addr == `CLRBP_G1) begin
                next_bptr[g] = 1'b0;
            end else if (i_io_addr == `MCLR_G0 || i_io_addr == `MCLR_G1) begin
                // extended modes deliberately survive a master clear
                next_cmd[g] = `CMD_RST;
                next_swreq[{g, 2'h0} +: 4] = 4'h0;
                next_mask[{g, 2'h0} +: 4] = 4'hf;
                next_bptr[g] = 1'b0;
                next_mclr[g] = 1'b1;
                for (int c = 0; c < 4; c++) begin
                    next_mode[{g, 2'(c)}] = `MODE_RST;
                end
                if (g) begin
                    next_mode[4] = `MODE_CASCADE_RST;
                end
            end
        end else if (i_io_rd) begin
            // base registers have no read path at all
            if (i_io_addr[7:3] == `CNT_PORT_BASE >> 3) begin
                next_rdata = bptr[g] ? cur_cnt[i_io_addr[2:0]][15:8]
                                     : cur_cnt[i_io_addr[2:0]][7:0];
                next_bptr[g] = !bptr[g];
            end else if (i_io_addr[7:3] == `CNT_HI_BASE >> 3) begin
                next_rdata = cur_cnt[i_io_addr[2:0]][23:16];
            end else if (i_io_addr == `MASKALL_G0 ||
                         i_io_addr == `MASKALL_G1) begin
                next_rdata = {4'h0, mask[{g, 2'h0} +: 4]};
            end
        end
        // one finished bus cycle: count falls by bytes or by one word
        if (pop) begin
            unique case (xmode[ch].size)
                dma_cnt_pkg::SZ_8_BYTES,
                dma_cnt_pkg::SZ_16_WORDS: dec = 24'h000001;
                dma_cnt_pkg::SZ_16_BYTES,
                dma_cnt_pkg::SZ_32_BYTES:
                    dec = {21'h000000, rec.bytes};
            endcase
            next_cur_cnt[ch] = cur_cnt[ch] - dec;
            if (cur_cnt[ch] < dec) begin
                next_tc[ch] = 1'b1;
                end_evt[ch] = 1'b1;
            end
        end
        // external end-of-process on the acknowledged channel
        if (i_dack_valid && xmode[i_dack_ch].eop_is_input && i_eop_in) begin
            end_evt[i_dack_ch] = 1'b1;
        end
        // hardware end events applied last so they beat software clears
        for (int c = 0; c < 8; c++) begin
            if (end_evt[c]) begin
                next_swreq[c] = 1'b0;
                if (mode[c].autoinit || i_chain_en[c]) begin
                    next_cur_cnt[c] = base_cnt[c];
                end else begin
                    next_mask[c] = 1'b1;
                end
            end
        end
        // software request ignores the mask; controller disable gates both
        for (int c = 0; c < 8; c++) begin
            next_req[c] = ((i_dreq[c] && !mask[c]) || swreq[c]) &&
                          !cmd[c / 4][`CMD_DISABLE_POS];
            next_stop[c] = xmode[c].stop_en;
        end
        // direction follows the acknowledge, driven only as an output
        next_eop_oe = i_dack_valid && !xmode[i_dack_ch].eop_is_input;
        next_eop_out = next_eop_oe && next_tc[i_dack_ch];
        unique case (xmode[i_dack_ch].size)
            dma_cnt_pkg::SZ_8_BYTES: next_step = 3'h1;
            dma_cnt_pkg::SZ_16_WORDS: next_step = 3'h1;
            dma_cnt_pkg::SZ_16_BYTES: next_step = 3'h2;
            dma_cnt_pkg::SZ_32_BYTES: next_step = 3'h4;
        endcase
        next_shift = xmode[i_dack_ch].size == dma_cnt_pkg::SZ_16_WORDS;
    end

    // register everything; only hardware reset loads extended defaults
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            for (int c = 0; c < 8; c++) begin
                cur_cnt[c] <= `CNT_RST;
                base_cnt[c] <= `CNT_RST;
                mode[c] <= (c == 4) ? `MODE_CASCADE_RST : `MODE_RST;
                xmode[c] <= (c < 4) ? `XMODE_RST_LO : `XMODE_RST_HI;
            end
            cmd[0] <= `CMD_RST;
            cmd[1] <= `CMD_RST;
            xsel[0] <= 3'h0;
            xsel[1] <= 3'h4;
            swreq <= 8'h00;
            mask <= 8'hff;
            bptr <= 2'h0;
            o_io_rdata <= 8'h00;
            o_terminal_count <= 8'h00;
            o_req_pending <= 8'h00;
            o_stop_cmp_en <= 8'h00;
            o_eop_out <= 1'b0;
            o_eop_oe <= 1'b0;
            o_addr_step <= 3'h1;
            o_addr_shift <= 1'b0;
            o_master_clear <= 2'h0;
        end else begin
            cur_cnt <= next_cur_cnt;
            base_cnt <= next_base_cnt;
            mode <= next_mode;
            xmode <= next_xmode;
            cmd <= next_cmd;
            xsel <= next_xsel;
            swreq <= next_swreq;
            mask <= next_mask;
            bptr <= next_bptr;
            o_io_rdata <= next_rdata;
            o_terminal_count <= next_tc;
            o_req_pending <= next_req;
            o_stop_cmp_en <= next_stop;
            o_eop_out <= next_eop_out;
            o_eop_oe <= next_eop_oe;
            o_addr_step <= next_step;
            o_addr_shift <= next_shift;
            o_master_clear <= next_mclr;
        end
    end

    // checks next to the logic they guard
    sequence s_cnt_lo_write;
        i_io_wr && i_io_addr == 8'h40 && !bptr[0];
    endsequence
    sequence s_zero_xfer;
        pop && rec.ch == 3'h0 && cur_cnt[0] == 24'h0 &&
            xmode[0].size == dma_cnt_pkg::SZ_8_BYTES;
    endsequence

    property p_hi_clear;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_cnt_lo_write |=> cur_cnt[0][23:16] == 8'h00 &&
            cur_cnt[0][7:0] == $past(i_io_wdata);
    endproperty
    a_hi_clear: assert property (p_hi_clear)
        else $error("count high byte not cleared");

    property p_tc_wrap;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_zero_xfer ##0 !mode[0].autoinit && !i_chain_en[0] |=>
            o_terminal_count[0] && cur_cnt[0] == 24'hffffff && mask[0];
    endproperty
    a_tc_wrap: assert property (p_tc_wrap)
        else $error("wrap without terminal count");

    property p_autoinit;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_zero_xfer ##0 mode[0].autoinit |=> cur_cnt[0] == $past(base_cnt[0]);
    endproperty
    a_autoinit: assert property (p_autoinit)
        else $error("autoinit did not reload");

    property p_tc_needs_zero;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(o_terminal_count[0]) |-> $past(pop) && $past(rec.ch) == 3'h0;
    endproperty
    a_tc_needs_zero: assert property (p_tc_needs_zero)
        else $error("terminal count without a transfer");

    property p_swreq_clr;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_terminal_count[0] |-> !swreq[0];
    endproperty
    a_swreq_clr: assert property (p_swreq_clr)
        else $error("software request survived terminal count");

    property p_mclr;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        i_io_wr && i_io_addr == 8'hda |=> mask[7:4] == 4'hf &&
            cmd[1] == 8'h00 && mode[4] == 6'h30 && swreq[7:4] == 4'h0;
    endproperty
    a_mclr: assert property (p_mclr)
        else $error("master clear incomplete");

    property p_xmode_keep;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        i_io_wr && i_io_addr == 8'h0d |=> xmode[0] == $past(xmode[0]);
    endproperty
    a_xmode_keep: assert property (p_xmode_keep)
        else $error("master clear touched extended mode");

    property p_step;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        xmode[i_dack_ch].size == dma_cnt_pkg::SZ_32_BYTES ##1
            $stable(i_dack_ch) |-> o_addr_step == 3'h4 && !o_addr_shift;
    endproperty
    a_step: assert property (p_step)
        else $error("32-bit step not four");

    property p_eop_dir;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        i_dack_valid && xmode[i_dack_ch].eop_is_input |=> !o_eop_oe;
    endproperty
    a_eop_dir: assert property (p_eop_dir)
        else $error("driving end-of-process while input");

    property p_req_mask;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        mask[0] && !swreq[0] && i_dreq[0] |=> !o_req_pending[0];
    endproperty
    a_req_mask: assert property (p_req_mask)
        else $error("masked request passed");
endmodule

// >>> dma_cnt_map.svh
// Purpose: offsets, field positions, reset values for the dma count block
// Assumes: 8-bit i/o address, byte-wide writes
// Notes: group 0 is channels 0-3, group 1 is channels 4-7
`ifndef DMA_CNT_MAP_SVH
`define DMA_CNT_MAP_SVH

// count ports: low/mid byte via byte pointer, high byte direct (+channel)
`define CNT_PORT_BASE 8'h40
`define CNT_HI_BASE 8'h50
// extended mode: low byte selects channel, high byte to last selected
`define XMODE_LO_G0 8'h60
`define XMODE_LO_G1 8'h61
`define XMODE_HI_G0 8'h62
`define XMODE_HI_G1 8'h63
`define CMD_G0 8'h08
`define CMD_G1 8'hd0
`define REQ_G0 8'h09
`define REQ_G1 8'hd2
`define MASK1_G0 8'h0a
`define MASK1_G1 8'hd4
`define MODE_G0 8'h0b
`define MODE_G1 8'hd6
`define CLRBP_G0 8'h0c
`define CLRBP_G1 8'hd8
`define MCLR_G0 8'h0d
`define MCLR_G1 8'hda
`define CLRMSK_G0 8'h0e
`define CLRMSK_G1 8'hdc
`define MASKALL_G0 8'h0f
`define MASKALL_G1 8'hde
// field positions
`define SETBIT_POS 2
`define CMD_DISABLE_POS 2
// reset values
`define CMD_RST 8'h00
`define MODE_RST 6'h00
`define MODE_CASCADE_RST 6'h30
`define XMODE_RST_LO 16'h0000
`define XMODE_RST_HI 16'h0004
`define CNT_RST 24'h000000
`define CNT_WRAP 24'hffffff
`define FIFO_DEPTH 32

`endif

// >>> dma_cnt_pkg.sv
// Purpose: types shared by the dma count block
// Assumes: field layout of the byte written by the host
// Notes: structs are packed msb first
package dma_cnt_pkg;

    typedef enum logic [1:0] {
        SZ_8_BYTES = 2'h0,
        SZ_16_WORDS = 2'h1,
        SZ_32_BYTES = 2'h2,
        SZ_16_BYTES = 2'h3
    } xfer_size_t;

    // data bits 7:2 of a mode write
    typedef struct packed {
        logic [1:0] svc_mode;  // 00 demand, 10 block, 11 cascade
        logic decrement;
        logic autoinit;
        logic [1:0] xfer_type; // 00 verify
    } chan_mode_t;

    typedef struct packed {
        logic [7:0] upper;
        logic stop_en;
        logic eop_is_input;
        logic [1:0] timing;
        xfer_size_t size;
        logic [1:0] sel;
    } ext_mode_t;

    // one completed bus cycle reported by the cycle engine
    typedef struct packed {
        logic [2:0] ch;
        logic [2:0] bytes;
    } xfer_rec_t;

endpackage

// >>> dma_periph_model.sv
// Purpose: peripheral side model that reports finished transfers
// Assumes: valid/ready record port of the count block
// Notes: record lines are scrambled when idle so stale data never matches
`timescale 1ns/10ps
module dma_periph_model (
    input wire logic i_clk_sys,
    input wire logic i_xfer_ready,
    output logic o_xfer_valid,
    output logic [5:0] o_xfer_rec
);
    initial begin
        o_xfer_valid = 1'b0;
        o_xfer_rec = 6'h3f;
    end

    // hold valid across back-to-back records, release only after ready
    task send(input logic [2:0] ch, input logic [2:0] nbytes, input int n);
        // align to an edge so two calls never drive valid in one step
        @(posedge i_clk_sys);
        for (int k = 0; k < n; k++) begin
            o_xfer_valid <= 1'b1;
            o_xfer_rec <= {ch, nbytes}; // bytes moved per bus cycle
            @(negedge i_clk_sys);
            while (i_xfer_ready !== 1'b1) @(negedge i_clk_sys);
            @(posedge i_clk_sys);
        end
        o_xfer_valid <= 1'b0;
        o_xfer_rec <= ~{ch, nbytes};
    endtask
endmodule

// >>> dma_channel_count_mode_regs_bench.sv
// Purpose: self-checking bench for the dma count and mode registers
// Assumes: host bytes per the address map header
// Notes: each scenario is a task that judges its own results
`timescale 1ns/10ps
`include "dma_cnt_map.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module dma_channel_count_mode_regs_bench;
    logic i_clk_sys = 0, i_sys_rst = 1, i_io_wr = 0, i_io_rd = 0;
    logic [7:0] i_io_addr = 0, i_io_wdata = 0, i_dreq = 0, o_io_rdata;
    logic i_dack_valid = 0, o_xfer_ready, i_xfer_valid, o_eop_out, o_eop_oe;
    logic [2:0] i_dack_ch = 0, o_addr_step;
    logic [5:0] i_xfer_rec;
    logic [7:0] o_terminal_count, o_req_pending, o_stop_cmp_en, tc_seen = 0;
    logic o_addr_shift;
    logic [7:0] chain_en = 0;
    logic eop_in = 0, eop_seen = 0;
    logic [1:0] o_master_clear;
    int error_cnt = 0, cmp_count = 0;

    always #25 i_clk_sys = ~i_clk_sys;
    // terminal count is a one-cycle pulse, so keep a sticky copy
    always @(posedge i_clk_sys) tc_seen <= tc_seen | o_terminal_count;
    always @(posedge i_clk_sys) eop_seen <= eop_seen | o_eop_out;

    dma_cnt_regs uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
        .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_dreq(i_dreq),
        .i_chain_en(chain_en), .i_dack_valid(i_dack_valid),
        .i_dack_ch(i_dack_ch), .i_xfer_valid(i_xfer_valid),
        .i_xfer_rec(i_xfer_rec), .o_xfer_ready(o_xfer_ready),
        .i_eop_in(eop_in), .o_eop_out(o_eop_out), .o_eop_oe(o_eop_oe),
        .o_terminal_count(o_terminal_count), .o_req_pending(o_req_pending),
        .o_stop_cmp_en(o_stop_cmp_en), .o_addr_step(o_addr_step),
        .o_addr_shift(o_addr_shift), .o_master_clear(o_master_clear));
    dma_periph_model p (.i_clk_sys(i_clk_sys), .i_xfer_ready(o_xfer_ready),
        .o_xfer_valid(i_xfer_valid), .o_xfer_rec(i_xfer_rec));

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_io_addr <= a;
        i_io_wdata <= d;
        i_io_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_io_wr <= 1'b0;
    endtask

    // read data is registered and stands one cycle after the read edge
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_io_addr <= a;
        i_io_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_io_rd <= 1'b0;
        #1 `CHK(o_io_rdata, e)
    endtask

    task dack(input logic [2:0] c);
        @(posedge i_clk_sys);
        i_dack_valid <= 1'b1;
        i_dack_ch <= c;
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask

    task t_reset;
        `CHK(o_addr_step, 3'h1)
        rd(`MASKALL_G0, 8'h0f);
        rd(`CNT_HI_BASE, 8'h00);
    endtask

    // count of 2 gives three transfers, wrap raises terminal count
    task t_count;
        wr(`CLRBP_G0, 8'h00);
        wr(`CNT_PORT_BASE, 8'h02);
        wr(`CNT_PORT_BASE, 8'h00);
        wr(`CLRMSK_G0, 8'h00);
        wr(`MODE_G0, 8'h80); // block mode ch0
        wr(`REQ_G0, 8'h04);
        i_dreq <= 8'h01;
        repeat (3) @(posedge i_clk_sys);
        #1 `CHK(o_req_pending[0], 1'b1)
        p.send(3'd0, 3'd1, 2);
        repeat (4) @(posedge i_clk_sys);
        #1 `CHK(tc_seen, 8'h00)
        p.send(3'd0, 3'd1, 1);
        repeat (4) @(posedge i_clk_sys);
        #1 `CHK(tc_seen, 8'h01)
        `CHK(o_req_pending[0], 1'b0)
        rd(`MASKALL_G0, 8'h01);
        wr(`CLRBP_G0, 8'h00);
        rd(`CNT_PORT_BASE, 8'hff);
        rd(`CNT_PORT_BASE, 8'hff);
        rd(`CNT_HI_BASE, 8'hff);
        // autoinit on ch0 and chaining on ch2 reload instead of masking
        wr(`MODE_G0, 8'h10);
        wr(`MASK1_G0, 8'h00);
        wr(`CNT_PORT_BASE, 8'h00);
        wr(`CNT_PORT_BASE, 8'h00);
        wr(`CNT_PORT_BASE + 8'h02, 8'h00);
        wr(`CNT_PORT_BASE + 8'h02, 8'h00);
        chain_en <= 8'h04;
        i_dack_valid <= 1'b1;
        p.send(3'd0, 3'd1, 1);
        p.send(3'd2, 3'd1, 1);
        repeat (4) @(posedge i_clk_sys);
        #1 `CHK(eop_seen, 1'b1)
        rd(`CNT_HI_BASE, 8'h00);
        rd(`CNT_HI_BASE + 8'h02, 8'h00);
        rd(`MASKALL_G0, 8'h00);
        chain_en <= 8'h00;
        i_dack_valid <= 1'b0;
        i_dreq <= 8'h00;
    endtask

    task t_hibyte;
        wr(`CNT_HI_BASE + 8'h01, 8'h12);
        rd(`CNT_HI_BASE + 8'h01, 8'h12);
        wr(`CLRBP_G0, 8'h00);
        wr(`CNT_PORT_BASE + 8'h01, 8'h07);
        rd(`CNT_HI_BASE + 8'h01, 8'h00);
    endtask

    // step, shift and end-of-process direction follow the acked channel
    task t_size;
        wr(`XMODE_LO_G0, 8'h08);
        wr(`XMODE_LO_G0, 8'h4d);
        wr(`XMODE_LO_G0, 8'h82);
        @(posedge i_clk_sys);
        #1 `CHK(o_stop_cmp_en, 8'h04)
        dack(3'd0);
        `CHK({o_addr_step, o_eop_oe, o_addr_shift}, 5'b100_1_0)
        dack(3'd1);
        `CHK({o_addr_step, o_eop_oe, o_addr_shift}, 5'b010_0_0)
        // an input end-of-process ends ch1 and masks it
        @(posedge i_clk_sys);
        eop_in <= 1'b1;
        @(posedge i_clk_sys);
        eop_in <= 1'b0;
        rd(`MASKALL_G0, 8'h02);
        dack(3'd4);
        `CHK({o_addr_step, o_eop_oe, o_addr_shift}, 5'b001_1_1)
        i_dack_valid <= 1'b0;
    endtask

    task t_swreq;
        wr(`MODE_G0, 8'h81); // block mode first
        wr(`REQ_G0, 8'h05);
        repeat (2) @(posedge i_clk_sys);
        #1 `CHK(o_req_pending, 8'h02)
        wr(`MCLR_G0, 8'h00);
        #1 `CHK(o_master_clear, 2'b01)
        repeat (2) @(posedge i_clk_sys);
        #1 `CHK(o_req_pending, 8'h00)
        rd(`MASKALL_G0, 8'h0f);
        wr(`MCLR_G1, 8'h00);
        #1 `CHK(o_master_clear, 2'b10)
        // extended mode of ch0 survives the master clear
        dack(3'd0);
        `CHK(o_addr_step, 3'h4)
        i_dack_valid <= 1'b0;
    endtask

    task test_done;
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        @(posedge i_clk_sys);
        #1 t_reset;
        t_count;
        t_hibyte;
        t_size;
        t_swreq;
        test_done;
    end

    // the scenarios need well under a thousand cycles
    initial begin
        #(50 * 4000);
        error_cnt++;
        test_done;
    end
endmodule
